// >>> hdl/dib_pkg.sv
`default_nettype none
package dib_pkg;
  // register byte addresses
  localparam logic [7:0] DIB_CFG_ONE_ADDR = 8'h00;
  localparam logic [7:0] DIB_CFG_TWO_ADDR = 8'h04;
  localparam logic [7:0] DIB_AUX_CFG_ADDR = 8'h08;
  localparam logic [7:0] DIB_COMP_ADDR = 8'h0C;
  localparam logic [7:0] DIB_FUNC_ADDR = 8'h10;
  localparam logic [7:0] DIB_DAC_ADDR = 8'h14;
  localparam logic [7:0] DIB_MEAS_ADDR = 8'h18;
  localparam logic [7:0] DIB_VOLT_ADDR = 8'h1C;
  // input_config_reg_one fields
  localparam int DIB_TIME_LSB = 0;
  localparam int DIB_TIME_W = 5;
  localparam int DIB_MODE_BIT = 5;
  localparam int DIB_INV_BIT = 6;
  // input_config_reg_two fields
  localparam int DIB_UNBUF_BIT = 0;
  // field widths and reset values
  localparam int DIB_AUX_W = 3;
  localparam int DIB_FUNC_W = 4;
  localparam int DIB_DAC_W = 14;
  localparam int DIB_MEAS_W = 16;
  localparam int DIB_CNT_W = 17;
  localparam logic [6:0] DIB_CFG_ONE_RST = 7'h00;
  localparam logic [2:0] DIB_AUX_RST = 3'h0;
  localparam logic [3:0] DIB_FUNC_RST = 4'h0;
  localparam logic [13:0] DIB_DAC_RST = 14'h0000;
  // aux pin function driving the debounced input
  localparam logic [2:0] DIB_AUX_DIN = 3'h3;
  // channel functions
  localparam logic [3:0] DIB_FUNC_HIZ = 4'h0;
  localparam logic [3:0] DIB_FUNC_DIN_LOOP = 4'h9;
  // span of loop-powered measurement in millivolts, full scale 2^16
  localparam int DIB_SPAN_MV = 12000;
  localparam int DIB_MEAS_SHIFT = 16;
  // timing
  localparam int DIB_CLK_NS = 10;
  localparam int DIB_SAMPLE_NS = 800;
  localparam int DIB_SAMPLE_CYC = DIB_SAMPLE_NS / DIB_CLK_NS;

  // debounce duration per time code in ns
  function automatic int unsigned dib_dur_ns(input logic [4:0] code);
    case (code)
      5'h01: return 13000;     5'h02: return 18700;     5'h03: return 24400;
      5'h04: return 32500;     5'h05: return 42300;     5'h06: return 56100;
      5'h07: return 75600;     5'h08: return 100800;    5'h09: return 130100;
      5'h0A: return 180500;    5'h0B: return 240600;    5'h0C: return 320300;
      5'h0D: return 420300;    5'h0E: return 560200;    5'h0F: return 750400;
      5'h10: return 1000800;   5'h11: return 1300800;   5'h12: return 1800800;
      5'h13: return 2400800;   5'h14: return 3200800;   5'h15: return 4200800;
      5'h16: return 5600800;   5'h17: return 7500700;   5'h18: return 10000700;
      5'h19: return 13000700;  5'h1A: return 18000600;  5'h1B: return 24000600;
      5'h1C: return 32000500;  5'h1D: return 42000400;  5'h1E: return 56000300;
      5'h1F: return 75000000;
      default: return 0;
    endcase
  endfunction : dib_dur_ns

  // samples per duration, rounded to nearest, at least one
  function automatic logic [DIB_CNT_W-1:0] dib_target(input logic [4:0] code);
    int unsigned t;
    t = (dib_dur_ns(code) + DIB_SAMPLE_NS / 2) / DIB_SAMPLE_NS;
    if (t == 0) begin
      t = 1;
    end
    return t[DIB_CNT_W-1:0];
  endfunction : dib_target
endpackage : dib_pkg
`default_nettype wire

// >>> hdl/dib_tick.sv
`timescale 1ns/1ps
`default_nettype none
module dib_tick
  import dib_pkg::*;
#(
  parameter int PERIOD = DIB_SAMPLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  output logic tick_q
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] cnt_q;

  // free-running divider, one pulse per sample period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      tick_q <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule : dib_tick
`default_nettype wire

// >>> hdl/dib_core.sv
`timescale 1ns/1ps
`default_nettype none
module dib_core
  import dib_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic sample,
  input wire logic mode,
  input wire logic bypass,
  input wire logic [DIB_CNT_W-1:0] target,
  output logic state_q,
  output logic [DIB_CNT_W-1:0] cnt_q
);
  logic [DIB_CNT_W-1:0] inc;
  assign inc = cnt_q + 1'b1;

  // one decision per sample tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= 1'b0;
      cnt_q <= '0;
    end else if (clk_en && tick) begin
      if (bypass) begin
        state_q <= sample;
        cnt_q <= '0;
      end else if (sample != state_q) begin
        // count toward the new level in both modes
        if (inc >= target) begin
          state_q <= sample;
          cnt_q <= '0;
        end else begin
          cnt_q <= inc;
        end
      end else if (mode) begin
        cnt_q <= '0;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1; // reversal undoes progress
      end
    end
  end
endmodule : dib_core
`default_nettype wire

// >>> hdl/dib_top.sv
// Contract
// - comparator watches sense-low pin; unbuffered enable makes it watch output pin.
// - comparator output sampled every 800 ns before debouncing.
// - 5-bit time code picks duration; code zero bypasses the debouncer.
// - codes 0x01 to 0x1F each select a fixed duration from the table.
// - one mode bit picks the algorithm; mode 0 after reset.
// - mode 0 counts up on differing samples, down on reverting ones.
// - mode 0 output takes the new level when the target count is met.
// - mode 1 counts differing samples, flips output and clears at target.
// - mode 1 clears the count whenever a sample matches the output.
// - conditioned result goes to comparator state register and aux pin.
// - aux pin in digital input function drives the debounced signal.
// - loop-powered mode sources current limited by the DAC code register.
// - loop-powered measurement spans 0 to 12 V as code/65536 times 12 V.
// - invert bit inverts the debounced signal into the state register.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dib_top
  import dib_pkg::*;
#(
  parameter int SAMPLE_CYC = DIB_SAMPLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // comparator results for each watched pin
  input wire logic comp_sense_low_pin,
  input wire logic comp_channel_output_pin,
  // converter result in loop-powered mode
  input wire logic [DIB_MEAS_W-1:0] adc_code,
  input wire logic adc_valid,
  // analog side controls
  output logic comp_watch_output_q,
  output logic current_source_en_q,
  output logic [DIB_DAC_W-1:0] current_limit_q,
  // first auxiliary pin
  output logic aux_pin_out_q,
  output logic aux_pin_oe_q
);
  // input_config_reg_one: time code, mode, invert
  logic [DIB_TIME_W-1:0] time_code_q;
  logic mode_q;
  logic invert_q;
  // input_config_reg_two
  logic unbuf_q;
  // other configuration
  logic [DIB_AUX_W-1:0] aux_cfg_q;
  logic [DIB_FUNC_W-1:0] func_q;
  logic [DIB_DAC_W-1:0] dac_q;
  logic [DIB_MEAS_W-1:0] meas_q;
  logic [DIB_MEAS_W-1:0] volt_mv_q;
  // datapath
  logic tick;
  logic sampled_q;
  logic [DIB_CNT_W-1:0] target_q;
  logic [DIB_TIME_W-1:0] target_code_q;
  logic deb_state;
  logic [DIB_CNT_W-1:0] deb_cnt;
  logic comp_state_q;
  // bus decode
  logic setup;
  logic access;
  logic wr_en;
  logic known;
  logic [31:0] rd_d;
  logic [31:0] volt_full;

  // --------------------------------------------------------------
  // apb handshake
  // --------------------------------------------------------------

  // setup cycle seen; access ends after exactly one wait-free cycle
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite;

  // every mapped offset is one aligned word
  always_comb begin
    unique case (paddr)
      DIB_CFG_ONE_ADDR, DIB_CFG_TWO_ADDR, DIB_AUX_CFG_ADDR,
      DIB_COMP_ADDR, DIB_FUNC_ADDR, DIB_DAC_ADDR,
      DIB_MEAS_ADDR, DIB_VOLT_ADDR: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // pready rises in the access cycle, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= setup;
    end
  end

  // unmapped addresses answer with an error and no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= setup && !known;
    end
  end

  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------

  // read data captured in setup, so it leaves a flop
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      DIB_CFG_ONE_ADDR: begin
        rd_d[DIB_TIME_LSB +: DIB_TIME_W] = time_code_q;
        rd_d[DIB_MODE_BIT] = mode_q;
        rd_d[DIB_INV_BIT] = invert_q;
      end
      DIB_CFG_TWO_ADDR: rd_d[DIB_UNBUF_BIT] = unbuf_q;
      DIB_AUX_CFG_ADDR: rd_d[DIB_AUX_W-1:0] = aux_cfg_q;
      DIB_COMP_ADDR: rd_d[0] = comp_state_q;
      DIB_FUNC_ADDR: rd_d[DIB_FUNC_W-1:0] = func_q;
      DIB_DAC_ADDR: rd_d[DIB_DAC_W-1:0] = dac_q;
      DIB_MEAS_ADDR: rd_d[DIB_MEAS_W-1:0] = meas_q;
      DIB_VOLT_ADDR: rd_d[DIB_MEAS_W-1:0] = volt_mv_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // hold read data across the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
    end
  end

  // --------------------------------------------------------------
  // writable registers, byte lane zero carries all fields but the upper dac code bits
  // --------------------------------------------------------------

  // time code, mode bit and invert bit; mode 0 after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_code_q <= DIB_CFG_ONE_RST[DIB_TIME_LSB +: DIB_TIME_W];
      mode_q <= DIB_CFG_ONE_RST[DIB_MODE_BIT];
      invert_q <= DIB_CFG_ONE_RST[DIB_INV_BIT];
    end else if (clk_en && wr_en && paddr == DIB_CFG_ONE_ADDR && pstrb[0]) begin
      time_code_q <= pwdata[DIB_TIME_LSB +: DIB_TIME_W];
      mode_q <= pwdata[DIB_MODE_BIT];
      invert_q <= pwdata[DIB_INV_BIT];
    end
  end

  // unbuffered enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unbuf_q <= 1'b0;
    end else if (clk_en && wr_en && paddr == DIB_CFG_TWO_ADDR && pstrb[0]) begin
      unbuf_q <= pwdata[DIB_UNBUF_BIT];
    end
  end

  // aux pin function select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_cfg_q <= DIB_AUX_RST;
    end else if (clk_en && wr_en && paddr == DIB_AUX_CFG_ADDR && pstrb[0]) begin
      aux_cfg_q <= pwdata[DIB_AUX_W-1:0];
    end
  end

  // channel function; high impedance after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q <= DIB_FUNC_RST;
    end else if (clk_en && wr_en && paddr == DIB_FUNC_ADDR && pstrb[0]) begin
      func_q <= pwdata[DIB_FUNC_W-1:0];
    end
  end

  // dac code, two byte lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_q <= DIB_DAC_RST;
    end else if (clk_en && wr_en && paddr == DIB_DAC_ADDR) begin
      if (pstrb[0]) begin
        dac_q[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        dac_q[DIB_DAC_W-1:8] <= pwdata[DIB_DAC_W-1:8];
      end
    end
  end

  // --------------------------------------------------------------
  // loop-powered current source and measurement
  // --------------------------------------------------------------

  // current limit follows the dac code only in loop-powered mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_source_en_q <= 1'b0;
      current_limit_q <= DIB_DAC_RST;
    end else if (clk_en) begin
      current_source_en_q <= (func_q == DIB_FUNC_DIN_LOOP);
      current_limit_q <= (func_q == DIB_FUNC_DIN_LOOP) ? dac_q : DIB_DAC_RST;
    end
  end

  // millivolts = code * 12000 / 65536, truncated
  assign volt_full = (32'(adc_code) * 32'(DIB_SPAN_MV)) >> DIB_MEAS_SHIFT;

  // latest conversion and its voltage, both held until the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_q <= '0;
      volt_mv_q <= '0;
    end else if (clk_en && adc_valid) begin
      meas_q <= adc_code;
      volt_mv_q <= volt_full[DIB_MEAS_W-1:0];
    end
  end

  // --------------------------------------------------------------
  // comparator source select
  // --------------------------------------------------------------

  // tells the analog side which pin the comparator watches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_watch_output_q <= 1'b0;
    end else if (clk_en) begin
      comp_watch_output_q <= unbuf_q;
    end
  end

  // --------------------------------------------------------------
  // sampling
  // --------------------------------------------------------------

  dib_tick #(
    .PERIOD(SAMPLE_CYC)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick_q(tick)
  );

  // one sample of the selected comparator each 800 ns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_q <= 1'b0;
    end else if (clk_en && tick) begin
      sampled_q <= unbuf_q ? comp_channel_output_pin : comp_sense_low_pin;
    end
  end

  // --------------------------------------------------------------
  // debounce target
  // --------------------------------------------------------------

  // recomputed when the code moves; the divide stays off the
  // counter path at the cost of one cycle of lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_code_q <= '0;
      target_q <= DIB_CNT_W'(1); // code zero bypasses, so the target is unused here
    end else if (clk_en && target_code_q != time_code_q) begin
      target_code_q <= time_code_q;
      target_q <= dib_target(time_code_q);
    end
  end

  // --------------------------------------------------------------
  // debouncer; samples lag the comparator by one tick
  // --------------------------------------------------------------

  dib_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .tick(tick),
    .sample(sampled_q),
    .mode(mode_q),
    .bypass(time_code_q == '0),
    .target(target_q),
    .state_q(deb_state),
    .cnt_q(deb_cnt)
  );

  // --------------------------------------------------------------
  // result delivery
  // --------------------------------------------------------------

  // software view, optionally inverted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_state_q <= 1'b0;
    end else if (clk_en) begin
      comp_state_q <= deb_state ^ invert_q;
    end
  end

  // aux pin carries the debounced level only in digital input function
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_pin_out_q <= 1'b0;
      aux_pin_oe_q <= 1'b0;
    end else if (clk_en) begin
      aux_pin_oe_q <= (aux_cfg_q == DIB_AUX_DIN);
      aux_pin_out_q <= (aux_cfg_q == DIB_AUX_DIN) && deb_state;
    end
  end

  // count value is internal only; kept visible for debug probes
  logic unused_cnt;
  assign unused_cnt = ^deb_cnt;
endmodule : dib_top
`default_nettype wire

// >>> tb/dib_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module dib_sensor_model (
  input wire logic level,
  input wire logic watch_output,
  output logic comp_sense_low_pin,
  output logic comp_channel_output_pin
);
  // the pin not watched shows the inverse, so a wrong pick cannot pass by chance
  always_comb begin
    comp_sense_low_pin = watch_output ? ~level : level;
    comp_channel_output_pin = watch_output ? level : ~level;
  end
endmodule : dib_sensor_model
`default_nettype wire

// >>> tb/dib_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dib_checker
  import dib_pkg::*;
#(
  parameter int SAMPLE_CYC = DIB_SAMPLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comp_watch_output_q,
  input wire logic current_source_en_q,
  input wire logic [DIB_DAC_W-1:0] current_limit_q,
  input wire logic aux_pin_oe_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed write, gated by the enable since a frozen cycle commits nothing
  logic wdone;
  assign wdone = psel && penable && pready && pwrite && clk_en;

  a_pready_after_setup: assert property (psel && !penable && clk_en ##1 clk_en |-> pready)
    else $error("no answer in the cycle after setup");
  a_pready_one_cycle: assert property (pready && clk_en |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_unmapped_err: assert property (psel && penable && pready |->
    pslverr == (paddr > 8'h1C || paddr[1:0] != 2'b00))
    else $error("error flag does not match address map");
  // config register lands on the write edge, the output flop one edge later
  a_watch_select: assert property (wdone && paddr == DIB_CFG_TWO_ADDR && pstrb[0] |-> ##2
    comp_watch_output_q == $past(pwdata[DIB_UNBUF_BIT], 2))
    else $error("watched pin select not taken from write");
  a_aux_drive: assert property (wdone && paddr == DIB_AUX_CFG_ADDR && pstrb[0] |-> ##2
    aux_pin_oe_q == ($past(pwdata[2:0], 2) == DIB_AUX_DIN))
    else $error("aux pin enable wrong after config write");
  a_source_enable: assert property (wdone && paddr == DIB_FUNC_ADDR && pstrb[0] |-> ##2
    current_source_en_q == ($past(pwdata[3:0], 2) == DIB_FUNC_DIN_LOOP))
    else $error("current source enable wrong after function write");
  a_limit_idle: assert property (!current_source_en_q ##1 !current_source_en_q |->
    current_limit_q == '0)
    else $error("current limit nonzero outside loop-powered mode");
  a_reset_quiet: assert property ($rose(presetn) |->
    !pready && !comp_watch_output_q && !current_source_en_q && !aux_pin_oe_q)
    else $error("outputs not idle after reset");
endmodule : dib_checker

bind dib_top dib_checker #(.SAMPLE_CYC(SAMPLE_CYC)) u_dib_checker (.pclk, .presetn, .clk_en,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .comp_watch_output_q,
  .current_source_en_q, .current_limit_q, .aux_pin_oe_q);
`default_nettype wire

// >>> tb/dib_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dib_top_tb;
  import dib_pkg::*;
  localparam int SC = 4;
  logic pclk, presetn, clk_en, psel, penable, pwrite, adc_valid, level, ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  logic [15:0] adc_code;
  logic pready, pslverr, s_low, s_out, watch, src_en, aux_out, aux_oe;
  logic [13:0] lim, dv;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 4301;
  int t;

  dib_top #(.SAMPLE_CYC(SC)) u_dib_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .comp_sense_low_pin(s_low),
    .comp_channel_output_pin(s_out), .adc_code, .adc_valid, .comp_watch_output_q(watch),
    .current_source_en_q(src_en), .current_limit_q(lim), .aux_pin_out_q(aux_out),
    .aux_pin_oe_q(aux_oe));
  dib_sensor_model u_dib_sensor_model (.level, .watch_output(watch),
    .comp_sense_low_pin(s_low), .comp_channel_output_pin(s_out));

  // free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one transfer; request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      n_errors++;
      report_and_stop();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // extra edges let derived output registers settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rv, exp);
  endtask : rdc

  // terminal level held for n sample ticks
  task automatic hold(input logic l, input int n);
    level <= l;
    repeat (n * SC) @(posedge pclk);
  endtask : hold

  // samples per debounce duration, rounded to nearest
  function automatic int tgt(input int c);
    int ns;
    ns = (c == 1) ? 13000 : (c == 2) ? 18700 : 24400;
    return (ns + 400) / 800;
  endfunction : tgt

  initial begin
    {psel, penable, pwrite, adc_valid, level} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    adc_code = 16'h0000;
    pstrb = 4'hF;
    clk_en = 1'b1;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 6; a++) rdc(8'(a * 4), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, ev}, 32'h1);
    check(rv, 32'h0);
    wr(8'h08, 32'h3);
    check({31'h0, aux_oe}, 32'h1);
    // bypass, random level and inversion, buffered then unbuffered
    for (int u = 0; u < 2; u++) begin
      wr(8'h04, 32'(u));
      check({31'h0, watch}, 32'(u));
      for (int k = 0; k < 8; k++) begin
        t = $random(seed);
        wr(8'h00, {25'h0, t[0], 6'h00});
        hold(t[1], 4);
        rdc(8'h0C, {31'h0, t[1] ^ t[0]});
        check({31'h0, aux_out}, {31'h0, t[1]});
      end
    end
    // a glitch one sample long: mode 0 gives back one count, mode 1 restarts
    for (int m = 0; m < 2; m++) begin
      for (int c = 1; c < 4; c++) begin
        wr(8'h00, 32'(m * 32 + c));
        hold(1'b0, tgt(c) + 4);
        hold(1'b1, tgt(c) - 2);
        rdc(8'h0C, 32'h0);
        hold(1'b0, 1);
        hold(1'b1, 8);
        rdc(8'h0C, 32'(m == 0));
        hold(1'b1, tgt(c) + 2);
        rdc(8'h0C, 32'h1);
        check({31'h0, aux_out}, 32'h1);
      end
    end
    // enable low freezes the debouncer and the pin while the input drops
    clk_en <= 1'b0;
    hold(1'b0, 8);
    clk_en <= 1'b1;
    check({31'h0, aux_out}, 32'h1);
    rdc(8'h0C, 32'h1);
    t = $random(seed);
    dv = t[13:0];
    wr(8'h14, 32'(dv));
    wr(8'h10, 32'h9);
    check({18'h0, lim}, 32'(dv));
    check({31'h0, src_en}, 32'h1);
    wr(8'h10, 32'h0);
    check({18'h0, lim}, 32'h0);
    // converter results, full scale first
    for (int k = 0; k < 4; k++) begin
      t = $random(seed);
      if (k == 0) t = 32'hFFFF;
      adc_code <= t[15:0];
      adc_valid <= 1'b1;
      @(posedge pclk);
      adc_valid <= 1'b0;
      rdc(8'h18, 32'(t[15:0]));
      rdc(8'h1C, (32'(t[15:0]) * 32'd12000) >> 16);
    end
    report_and_stop();
  end
endmodule : dib_top_tb
`default_nettype wire
